// *** rps_ind_model.sv ***
`timescale 1ns/1ns
module rps_ind_model
  import rps_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Window strobes
  input  wire rps_sel_e   ind_sel,
  input  wire logic       ind_wr,
  input  wire logic [7:0] ind_wdata,
  output logic      [7:0] ind_rdata
);
  logic [7:0] regs [0:7];
  initial begin
    for (int i = 0; i < 8; i++) regs[i] = 8'h00;
  end
  // One byte behind each select code
  always @(posedge clk) begin
    if (ind_wr === 1'b1) regs[ind_sel] <= ind_wdata;
  end
  assign ind_rdata = regs[ind_sel];
endmodule

// *** rps_lane_swap.sv ***
`timescale 1ns/1ns
package rps_pkg;
  localparam int          BUS_AW        = 5;
  localparam logic [4:0]  OFS_PTR_LOW   = 5'h00;
  localparam logic [4:0]  OFS_PTR_HIGH  = 5'h04;
  localparam logic [4:0]  OFS_IND_SEL   = 5'h08;
  localparam logic [4:0]  OFS_IND_DATA  = 5'h0c;
  localparam logic [4:0]  OFS_CONTROL   = 5'h10;
  localparam int          CTL_WIDE_BIT  = 0;
  localparam int          SEL_W         = 3;
  localparam int          HIGH_W        = 3;
  localparam int          RAM_AW        = 11;
  localparam logic [6:0]  PTR_LOW_RST   = 7'h00;
  localparam logic [2:0]  PTR_HIGH_RST  = 3'h0;
  localparam logic [2:0]  IND_SEL_RST   = 3'h0;
  localparam logic        WIDE_RST      = 1'b0;

  typedef enum logic [2:0] {
    RPS_SEL_TENT_ID,
    RPS_SEL_NODE_ID,
    RPS_SEL_SETUP1,
    RPS_SEL_NEXT_ID,
    RPS_SEL_SETUP2,
    RPS_SEL_BUS_CTRL,
    RPS_SEL_DMA_COUNT,
    RPS_SEL_RESERVED
  } rps_sel_e;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } rps_lanes_s;

  typedef struct packed {
    logic [7:0] odd;
    logic [7:0] even;
  } rps_bytes_s;

  function automatic logic rps_even_on_upper(input logic dir_mode, input logic swap);
    // Strobe mode: swap 0 puts odd on upper; dir/ds mode: swap 0 puts even on upper
    return dir_mode ^ swap;
  endfunction
endpackage

module rps_lane_swap
  import rps_pkg::*;
(
  // Mode
  input  wire logic       dir_mode,
  input  wire logic       swap,
  // Memory to bus
  input  wire rps_bytes_s mem_bytes,
  output rps_lanes_s      bus_lanes,
  // Bus to memory
  input  wire rps_lanes_s host_lanes,
  output rps_bytes_s      host_bytes
);
  wire even_up = rps_even_on_upper(dir_mode, swap);

  assign bus_lanes.upper  = even_up ? mem_bytes.even : mem_bytes.odd;
  assign bus_lanes.lower  = even_up ? mem_bytes.odd  : mem_bytes.even;
  assign host_bytes.even  = even_up ? host_lanes.upper : host_lanes.lower;
  assign host_bytes.odd   = even_up ? host_lanes.lower : host_lanes.upper;
endmodule

// *** rps_ptr_subaddr.sv ***
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
// Overview of operation
// - The pointer low register holds RAM address bits 7 to 0 with the wide bus disabled, and bits 7 to 1 with it enabled.
// - With the wide bus enabled, pointer low bit 0 acts as the byte-swap control, not an address bit.
// - The byte-swap control is left uninitialised by reset; until pointer low is written, RAM address bit 0, the pointer low read and the lane mapping depend on it.
// - The swap setting steers byte lanes for both processor and DMA cycles alike.
// - Strobe mode swap 0 puts odd on upper lane, dir/ds mode swap 0 puts even on upper, swap 1 reverses.
// - The three-bit select field picks which indirect register the address 07 window reaches.
// - Select codes map tentative ID, node ID, setup one, next ID, setup two, bus control, DMA count, reserved.
// - RAM address bits 10 to 8 come from the pointer high bits and join the low byte into 11 bits.
module rps_ptr_subaddr
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Host interface mode pin
  input  wire logic              dir_mode_pin,
  // RAM side
  output logic      [RAM_AW-1:0] ram_addr,
  output logic                   wide_bus_enable,
  input  wire rps_bytes_s        mem_bytes,
  output rps_lanes_s             bus_lanes,
  input  wire rps_lanes_s        host_lanes,
  output rps_bytes_s             host_bytes,
  // Indirect register window
  output rps_sel_e               ind_sel,
  output logic                   ind_wr,
  output logic                   ind_rd,
  output logic      [7:0]        ind_wdata,
  input  wire logic [7:0]        ind_rdata
);
  logic [7:1]        ptr_low_hi;
  logic              swap_bit;
  logic [HIGH_W-1:0] ram_addr_high_bits;
  logic              ack;
  logic              dir_meta;
  logic              dir_mode;
  rps_lanes_s        next_lanes;
  rps_bytes_s        next_bytes;

  wire       req        = (read | write) & ~ack;
  wire       hit_low    = address == OFS_PTR_LOW;
  wire       hit_high   = address == OFS_PTR_HIGH;
  wire       hit_sel    = address == OFS_IND_SEL;
  wire       hit_data   = address == OFS_IND_DATA;
  wire       hit_ctl    = address == OFS_CONTROL;
  wire       sel_live   = ind_sel != RPS_SEL_RESERVED;
  wire       wr_take    = write & req;
  wire [7:0] ram_addr_low_bits = {ptr_low_hi, swap_bit};

  assign waitrequest = (read | write) & ~ack;
  assign ind_wr      = wr_take & hit_data & sel_live;
  assign ind_rd      = read & req & hit_data & sel_live;
  assign ind_wdata   = writedata[7:0];
  // Word access in wide mode: bit 0 is no longer part of the address
  assign ram_addr    = {ram_addr_high_bits, ram_addr_low_bits[7:1],
                        ram_addr_low_bits[0] & ~wide_bus_enable};

  wire [7:0] rd_mux =
      hit_low  ? ram_addr_low_bits :
      hit_high ? {5'h00, ram_addr_high_bits} :
      hit_sel  ? {5'h00, ind_sel} :
      (hit_data & sel_live) ? ind_rdata :
      hit_ctl  ? {7'h00, wide_bus_enable} : 8'h00;

  always_ff @(posedge clk) begin
    dir_meta <= dir_mode_pin;
    dir_mode <= dir_meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack <= 1'b0;
      readdata <= 32'h0;
    end else begin
      ack <= req;
      if (read & req) begin
        readdata <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_low_hi <= PTR_LOW_RST;
      ram_addr_high_bits <= PTR_HIGH_RST;
      ind_sel <= rps_sel_e'(IND_SEL_RST);
      wide_bus_enable <= WIDE_RST;
    end else if (wr_take) begin
      if (hit_low) begin
        ptr_low_hi <= writedata[7:1];
      end
      if (hit_high) begin
        ram_addr_high_bits <= writedata[HIGH_W-1:0];
      end
      if (hit_sel) begin
        ind_sel <= rps_sel_e'(writedata[SEL_W-1:0]);
      end
      if (hit_ctl) begin
        wide_bus_enable <= writedata[CTL_WIDE_BIT];
      end
    end
  end

  // Swap bit deliberately outside reset
  always_ff @(posedge clk) begin
    if (wr_take & hit_low) begin
      swap_bit <= writedata[0];
    end
  end

  // One lane mapping shared by processor and DMA cycles
  rps_lane_swap u_swap (
    .dir_mode   (dir_mode),
    .swap       (swap_bit),
    .mem_bytes  (mem_bytes),
    .bus_lanes  (next_lanes),
    .host_lanes (host_lanes),
    .host_bytes (next_bytes)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_lanes <= '0;
      host_bytes <= '0;
    end else begin
      bus_lanes <= next_lanes;
      host_bytes <= next_bytes;
    end
  end

  sequence seq_write_taken(logic [4:0] ofs);
    write && !waitrequest && address == ofs;
  endsequence

  sequence seq_req_open;
    (read || write) && !ack;
  endsequence

  a_low_addr_bits: assert property (@(posedge clk) disable iff (!rst_b)
    seq_write_taken(OFS_PTR_LOW) |=> ram_addr[7:1] == $past(writedata[7:1]))
    else $error("pointer low not on ram address");
  a_swap_not_addr: assert property (@(posedge clk) disable iff (!rst_b)
    wide_bus_enable |-> ram_addr[0] == 1'b0)
    else $error("swap bit leaked into address");
  a_high_addr_bits: assert property (@(posedge clk) disable iff (!rst_b)
    seq_write_taken(OFS_PTR_HIGH) |=> ram_addr[10:8] == $past(writedata[2:0]))
    else $error("pointer high not on ram address");
  a_lane_order_map: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> bus_lanes.upper ==
      (($past(dir_mode) ^ $past(swap_bit)) ? $past(mem_bytes.even) : $past(mem_bytes.odd)))
    else $error("upper lane holds wrong byte");
  a_lane_write_map: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> host_bytes.even ==
      (($past(dir_mode) ^ $past(swap_bit)) ? $past(host_lanes.upper) : $past(host_lanes.lower)))
    else $error("even byte taken from wrong lane");
  a_sel_write_upd: assert property (@(posedge clk) disable iff (!rst_b)
    seq_write_taken(OFS_IND_SEL) |=> ind_sel == $past(writedata[2:0]))
    else $error("select field not updated");
  a_sel_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    read && !waitrequest && $past(address) == OFS_IND_SEL && $past(read) |-> readdata[7:3] == 5'h00)
    else $error("reserved select bits read nonzero");
  a_reserved_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    ind_sel == RPS_SEL_RESERVED |-> !ind_wr && !ind_rd)
    else $error("reserved select code reached a register");
  a_window_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    seq_req_open ##0 (write && address == OFS_IND_DATA && ind_sel != RPS_SEL_RESERVED)
      |-> ind_wr ##1 (!waitrequest && !ind_wr))
    else $error("window write strobe wrong");
  a_wait_bounded: assert property (@(posedge clk) disable iff (!rst_b)
    seq_req_open |=> !waitrequest)
    else $error("waitrequest held too long");

  // Read strobes, read data and no window strobes without a request
  a_read_win_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    seq_req_open ##0 (read && address == OFS_IND_DATA && ind_sel != RPS_SEL_RESERVED)
      |-> ind_rd ##1 (!waitrequest && !ind_rd))
    else $error("window read strobe wrong");
  a_reserved_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
    seq_req_open ##0 (read && address == OFS_IND_DATA && ind_sel == RPS_SEL_RESERVED)
      |=> readdata == 32'h00000000)
    else $error("reserved window read not zero");
  a_read_upper_zero: assert property (@(posedge clk) disable iff (!rst_b)
    read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("read data upper bits nonzero");
  a_idle_no_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    !(read || write) |-> !ind_wr && !ind_rd)
    else $error("window strobe without request");

  // Wide and swap load on their own writes; pointer and select change only on their own writes
  a_wide_ctl_upd: assert property (@(posedge clk) disable iff (!rst_b)
    seq_write_taken(OFS_CONTROL) |=> wide_bus_enable == $past(writedata[CTL_WIDE_BIT]))
    else $error("wide enable not updated");
  a_swap_bit_load: assert property (@(posedge clk) disable iff (!rst_b)
    seq_write_taken(OFS_PTR_LOW) |=> swap_bit == $past(writedata[0]))
    else $error("swap bit not loaded");
  a_low_only_written: assert property (@(posedge clk) disable iff (!rst_b)
    !(write && address == OFS_PTR_LOW) |=> $stable(ram_addr[7:1]))
    else $error("pointer low changed without write");
  a_high_only_written: assert property (@(posedge clk) disable iff (!rst_b)
    !(write && address == OFS_PTR_HIGH) |=> $stable(ram_addr[10:8]))
    else $error("pointer high changed without write");
  a_sel_only_written: assert property (@(posedge clk) disable iff (!rst_b)
    !(write && address == OFS_IND_SEL) |=> $stable(ind_sel))
    else $error("select changed without write");

  // Lower lane and odd byte steering
  a_lane_lower_map: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> bus_lanes.lower ==
      (($past(dir_mode) ^ $past(swap_bit)) ? $past(mem_bytes.odd) : $past(mem_bytes.even)))
    else $error("lower lane holds wrong byte");
  a_lane_odd_map: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> host_bytes.odd ==
      (($past(dir_mode) ^ $past(swap_bit)) ? $past(host_lanes.lower) : $past(host_lanes.upper)))
    else $error("odd byte taken from wrong lane");
endmodule

// *** rps_ptr_subaddr_tb.sv ***
`timescale 1ns/1ns
module rps_ptr_subaddr_tb
  import rps_pkg::*;
;
  logic              clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, dir_mode_pin = 1'b0;
  logic [BUS_AW-1:0] address = '0;
  logic [31:0]       writedata = '0, readdata, rd;
  logic              waitrequest, wide_bus_enable, ind_wr, ind_rd;
  logic [RAM_AW-1:0] ram_addr;
  rps_bytes_s        mem_bytes = '0, host_bytes;
  rps_lanes_s        host_lanes = '0, bus_lanes;
  rps_sel_e          ind_sel;
  logic [7:0]        ind_wdata, ind_rdata, lo, hi, d, kept [0:7];
  int                error_cnt = 0, n_checks = 0;
  int                n_wr_pulse = 0, n_rd_pulse = 0;
  always #4 clk = ~clk;
  rps_ptr_subaddr rps_ptr_subaddr_inst (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .dir_mode_pin(dir_mode_pin), .ram_addr(ram_addr), .wide_bus_enable(wide_bus_enable),
    .mem_bytes(mem_bytes), .bus_lanes(bus_lanes), .host_lanes(host_lanes), .host_bytes(host_bytes),
    .ind_sel(ind_sel), .ind_wr(ind_wr), .ind_rd(ind_rd), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata));
  rps_ind_model rps_ind_model_inst (.clk(clk), .ind_sel(ind_sel), .ind_wr(ind_wr),
    .ind_wdata(ind_wdata), .ind_rdata(ind_rdata));
  // Count window strobes for the end-of-run totals
  always @(posedge clk) begin
    if (ind_wr === 1'b1) n_wr_pulse++;
    if (ind_rd === 1'b1) n_rd_pulse++;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hold request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [7:0] v);
    address <= a;
    writedata <= {24'h000000, v};
    read <= ~wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  // Lane order expected for mode and swap
  function automatic rps_lanes_s exp_lanes(input logic dm, input logic s, input rps_bytes_s b);
    return (dm == s) ? {b.odd, b.even} : {b.even, b.odd};
  endfunction
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(92));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_PTR_HIGH, 8'h00); chk("ptr_high_rst", rd, 32'h0);
    bus(1'b0, OFS_IND_SEL, 8'h00); chk("sel_rst", rd, 32'h0);
    chk("wide_rst", wide_bus_enable, 1'b0);
    bus(1'b1, 5'h14, 8'h5a); bus(1'b0, 5'h14, 8'h00); chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      lo = (i == 0) ? 8'hff : 8'($urandom);
      hi = (i == 0) ? 8'h07 : 8'($urandom);
      bus(1'b1, OFS_PTR_LOW, lo);
      bus(1'b1, OFS_PTR_HIGH, hi);
      chk("ram_addr", ram_addr, {hi[2:0], lo});
      bus(1'b0, OFS_PTR_LOW, 8'h00); chk("ptr_low", rd, lo);
    end
    for (int c = 0; c < 8; c++) begin
      d = 8'($urandom);
      bus(1'b1, OFS_IND_SEL, {5'($urandom), 3'(c)});
      bus(1'b0, OFS_IND_SEL, 8'h00); chk("sel_rd", rd, c);
      chk("ind_sel", ind_sel, c);
      bus(1'b1, OFS_IND_DATA, d);
      kept[c] = (c == 7) ? 8'h00 : d;
      bus(1'b0, OFS_IND_DATA, 8'h00); chk("window", rd, kept[c]);
    end
    bus(1'b1, OFS_IND_SEL, 8'h06);
    bus(1'b0, OFS_IND_DATA, 8'h00); chk("reserved_no_touch", rd, kept[6]);
    chk("reserved_kept", rps_ind_model_inst.regs[7], 8'h00);
    for (int k = 0; k < 8; k++) begin
      lo = {7'($urandom), k[0]};
      bus(1'b1, OFS_CONTROL, 8'h00);
      bus(1'b1, OFS_PTR_LOW, lo);
      bus(1'b1, OFS_CONTROL, 8'h01);
      chk("wide", wide_bus_enable, 1'b1);
      chk("addr_bit0", ram_addr[0], 1'b0);
      dir_mode_pin <= k[1];
      mem_bytes <= 16'($urandom);
      host_lanes <= 16'($urandom);
      repeat (5) @(posedge clk);
      chk("bus_lanes", bus_lanes, exp_lanes(k[1], k[0], mem_bytes));
      chk("host_bytes", host_bytes, exp_lanes(k[1], k[0], host_lanes));
    end
    // Reset in mid-run: registers other than the swap bit return to their reset values
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk("wide_rst2", wide_bus_enable, 1'b0);
    chk("addr_rst2", ram_addr[10:1], 10'h000);
    bus(1'b0, OFS_IND_SEL, 8'h00); chk("sel_rst2", rd, 32'h0);
    chk("wr_pulses", n_wr_pulse, 7);
    chk("rd_pulses", n_rd_pulse, 8);
    finish_test();
  end
endmodule
